// ==== pkg/pll_cfg_pkg.sv ====
// constants and types for the sampling pll divider configuration block
package pll_cfg_pkg;
   // serial control frame: read flag, 15-bit address, 8-bit data
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam logic [4:0] HEADER_LAST = 5'h0f;
   localparam logic [4:0] FRAME_LAST = 5'h17;

   localparam logic [14:0] REF_OUT_CTRL_OFS = 15'h003c;
   localparam logic [14:0] FB_DIV_VP_OFS = 15'h003d;
   localparam logic [14:0] FB_DIV_N_OFS = 15'h003e;
   localparam logic [14:0] OSCILLATOR_BIAS_LEVEL_OFS = 15'h003f;
   localparam logic [14:0] PRE_EMPH_OFS = 15'h0048;
   localparam logic [14:0] PIN_OVR_OFS = 15'h0058;

   localparam logic [7:0] REF_OUT_CTRL_RST = 8'h01;
   localparam logic [7:0] FB_DIV_VP_RST = 8'h00;
   localparam logic [7:0] FB_DIV_N_RST = 8'h20;
   localparam logic [7:0] OSCILLATOR_BIAS_LEVEL_RST = 8'h4f;
   localparam logic [7:0] PRE_EMPH_RST = 8'h00;
   localparam logic [7:0] PIN_OVR_RST = 8'h00;
   localparam logic [6:0] OSCILLATOR_BIAS_LEVEL_RECOMMENDED = 7'h4a;

   localparam int REF_OUT_EN_BIT = 0;
   localparam int V_DIV_LSB = 0;
   localparam int P_DIV_LSB = 2;
   localparam int N_DIV_LSB = 0;
   localparam int N_DIV_W = 6;
   localparam int BIAS_W = 7;
   localparam int PE_W = 4;
   localparam int OVR_EN_BIT = 7;
   localparam int OVR_PLL_EN_BIT = 0;
   localparam int TOTAL_W = 11;

   localparam logic [1:0] CODE_0 = 2'h0;
   localparam logic [1:0] CODE_1 = 2'h1;
   localparam logic [1:0] CODE_2 = 2'h2;
   localparam logic [2:0] V_RATIO_0 = 3'h5;
   localparam logic [2:0] V_RATIO_1 = 3'h4;
   localparam logic [2:0] V_RATIO_2 = 3'h3;
   localparam logic [2:0] P_RATIO_0 = 3'h1;
   localparam logic [2:0] P_RATIO_1 = 3'h2;
   localparam logic [2:0] P_RATIO_2 = 3'h4;
   localparam logic [5:0] N_RATIO_RST = 6'h20;

   typedef struct packed {
      logic read;
      logic [14:0] addr;
   } spi_cmd_s;

   typedef struct packed {
      logic [2:0] v;
      logic [2:0] p;
      logic [5:0] n;
   } fb_ratio_s;
endpackage

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser for asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // pins and their synchronised copies
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== verilog/sampling_pll_divider_config.sv ====
// serial-port register file and divider configuration for the sampling pll
`timescale 1ns/100ps
module sampling_pll_divider_config #(
   parameter int LANES = 8
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // serial control port
   input wire logic spi_sclk_in,
   input wire logic spi_csn_in,
   input wire logic spi_sdi_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_out,
   // pll enable pin
   input wire logic pll_enable_pin_in,
   // configuration outputs
   output logic pll_enable_out,
   output logic ref_out_enable_out,
   output pll_cfg_pkg::fb_ratio_s fb_ratio_out,
   output logic [pll_cfg_pkg::TOTAL_W-1:0] total_ratio_out,
   output logic [pll_cfg_pkg::BIAS_W-1:0] oscillator_bias_level_out,
   output logic [LANES-1:0][pll_cfg_pkg::PE_W-1:0] lane_pre_emphasis_level_out
);
   logic sclk_s, csn_s, sdi_s, pin_en_s;
   logic cs_act_s;
   logic sclk_prev_q;
   logic sclk_rise, sclk_fall;
   logic [4:0] bit_cnt_q;
   logic [23:0] shift_q;
   logic [23:0] shift_d;
   pll_cfg_pkg::spi_cmd_s cmd_q;
   logic header_done_q;
   logic [7:0] tx_q;
   logic [7:0] rd_data;
   logic wr_en;
   logic [7:0] ref_ctrl_q, fb_vp_q, fb_n_q, bias_q, pe_q, ovr_q;
   logic [1:0] v_code, p_code;
   logic [5:0] n_code;

   // slow sampling of the port: sclk must stay under a quarter of clock_in
   pin_sync #(.WIDTH(4)) u_sync (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .async_in({spi_sclk_in, ~spi_csn_in, spi_sdi_in, pll_enable_pin_in}),
      .sync_out({sclk_s, cs_act_s, sdi_s, pin_en_s})
   );

   // select synced inverted so the cleared synchroniser reads as deselected
   assign csn_s = ~cs_act_s;

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_prev_q & ~csn_s;
   assign sclk_fall = ~sclk_s & sclk_prev_q & ~csn_s;
   assign shift_d = {shift_q[22:0], sdi_s};
   assign wr_en = sclk_rise && (bit_cnt_q == pll_cfg_pkg::FRAME_LAST)
                  && header_done_q && !cmd_q.read;

   // frame bit counter and input shifter; chip select high aborts a frame
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bit_cnt_q <= 5'h00;
         shift_q <= 24'h000000;
      end else if (csn_s) begin
         bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         shift_q <= shift_d;
         // stops one past the last bit so extra clocks cannot rewrite
         if (bit_cnt_q <= pll_cfg_pkg::FRAME_LAST) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   // header capture
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cmd_q <= '0;
         header_done_q <= 1'b0;
      end else if (csn_s) begin
         header_done_q <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == pll_cfg_pkg::HEADER_LAST) begin
         cmd_q <= pll_cfg_pkg::spi_cmd_s'(shift_d[15:0]);
         header_done_q <= 1'b1;
      end
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      rd_data = 8'h00;
      case (shift_d[14:0])
         pll_cfg_pkg::REF_OUT_CTRL_OFS: rd_data = ref_ctrl_q;
         pll_cfg_pkg::FB_DIV_VP_OFS: rd_data = fb_vp_q;
         pll_cfg_pkg::FB_DIV_N_OFS: rd_data = fb_n_q;
         pll_cfg_pkg::OSCILLATOR_BIAS_LEVEL_OFS: rd_data = bias_q;
         pll_cfg_pkg::PRE_EMPH_OFS: rd_data = pe_q;
         pll_cfg_pkg::PIN_OVR_OFS: rd_data = ovr_q;
         default: rd_data = 8'h00;
      endcase
   end

   // read data leaves msb first on falling sclk after the header
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_q <= 8'h00;
         spi_sdo_out <= 1'b0;
         spi_sdo_oe_out <= 1'b0;
      end else if (csn_s) begin
         spi_sdo_oe_out <= 1'b0;
         spi_sdo_out <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == pll_cfg_pkg::HEADER_LAST) begin
         tx_q <= rd_data;
         spi_sdo_oe_out <= shift_d[15];
      end else if (sclk_fall && header_done_q && cmd_q.read) begin
         spi_sdo_out <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // register writes; reserved bits are stored as written
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ref_ctrl_q <= pll_cfg_pkg::REF_OUT_CTRL_RST;
         fb_vp_q <= pll_cfg_pkg::FB_DIV_VP_RST;
         fb_n_q <= pll_cfg_pkg::FB_DIV_N_RST;
         bias_q <= pll_cfg_pkg::OSCILLATOR_BIAS_LEVEL_RST;
         pe_q <= pll_cfg_pkg::PRE_EMPH_RST;
         ovr_q <= pll_cfg_pkg::PIN_OVR_RST;
      end else if (wr_en) begin
         case (cmd_q.addr)
            pll_cfg_pkg::REF_OUT_CTRL_OFS: ref_ctrl_q <= shift_d[7:0];
            pll_cfg_pkg::FB_DIV_VP_OFS: fb_vp_q <= shift_d[7:0];
            pll_cfg_pkg::FB_DIV_N_OFS: fb_n_q <= shift_d[7:0];
            pll_cfg_pkg::OSCILLATOR_BIAS_LEVEL_OFS: bias_q <= shift_d[7:0];
            pll_cfg_pkg::PRE_EMPH_OFS: pe_q <= shift_d[7:0];
            pll_cfg_pkg::PIN_OVR_OFS: ovr_q <= shift_d[7:0];
            default: ;
         endcase
      end
   end

   // pll enable source and reference output buffer
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pll_enable_out <= 1'b0;
         ref_out_enable_out <= 1'b0;
      end else begin
         pll_enable_out <= ovr_q[pll_cfg_pkg::OVR_EN_BIT] ?
            ovr_q[pll_cfg_pkg::OVR_PLL_EN_BIT] : pin_en_s;
         ref_out_enable_out <= ref_ctrl_q[pll_cfg_pkg::REF_OUT_EN_BIT]
                               & pll_enable_out;
      end
   end

   assign v_code = fb_vp_q[pll_cfg_pkg::V_DIV_LSB +: 2];
   assign p_code = fb_vp_q[pll_cfg_pkg::P_DIV_LSB +: 2];
   assign n_code = fb_n_q[pll_cfg_pkg::N_DIV_LSB +: pll_cfg_pkg::N_DIV_W];

   // decoded ratios; reserved codes hold the last valid ratio
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fb_ratio_out.v <= pll_cfg_pkg::V_RATIO_0;
         fb_ratio_out.p <= pll_cfg_pkg::P_RATIO_0;
         fb_ratio_out.n <= pll_cfg_pkg::N_RATIO_RST;
      end else begin
         case (v_code)
            pll_cfg_pkg::CODE_0: fb_ratio_out.v <= pll_cfg_pkg::V_RATIO_0;
            pll_cfg_pkg::CODE_1: fb_ratio_out.v <= pll_cfg_pkg::V_RATIO_1;
            pll_cfg_pkg::CODE_2: fb_ratio_out.v <= pll_cfg_pkg::V_RATIO_2;
            default: ;
         endcase
         case (p_code)
            pll_cfg_pkg::CODE_0: fb_ratio_out.p <= pll_cfg_pkg::P_RATIO_0;
            pll_cfg_pkg::CODE_1: fb_ratio_out.p <= pll_cfg_pkg::P_RATIO_1;
            pll_cfg_pkg::CODE_2: fb_ratio_out.p <= pll_cfg_pkg::P_RATIO_2;
            default: ;
         endcase
         if (n_code != 6'h00) begin
            fb_ratio_out.n <= n_code;
         end
      end
   end

   // total ratio lags the decoded ratios by one cycle
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         total_ratio_out <= 11'(pll_cfg_pkg::V_RATIO_0)
                            * 11'(pll_cfg_pkg::P_RATIO_0)
                            * 11'(pll_cfg_pkg::N_RATIO_RST);
      end else begin
         total_ratio_out <= 11'(fb_ratio_out.v) * 11'(fb_ratio_out.p)
                            * 11'(fb_ratio_out.n);
      end
   end

   // analog settings; one pre-emphasis level fans out to all lanes
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         oscillator_bias_level_out <= pll_cfg_pkg::OSCILLATOR_BIAS_LEVEL_RST[6:0];
         lane_pre_emphasis_level_out <= '0;
      end else begin
         oscillator_bias_level_out <= bias_q[pll_cfg_pkg::BIAS_W-1:0];
         lane_pre_emphasis_level_out <=
            {LANES{pe_q[pll_cfg_pkg::PE_W-1:0]}};
      end
   end

   ref_out_gate_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
      ref_out_enable_out == ($past(ref_ctrl_q[0]) && $past(pll_enable_out)))
      else $error("reference output on without both enables");
   ref_en_reset_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
      !$past(rstn_in) |-> ref_ctrl_q == 8'h01)
      else $error("reference enable not set after reset");
   p_ratio_decode_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in)
      fb_vp_q[3:2] == 2'h2 |=> fb_ratio_out.p == 3'h4)
      else $error("second divider code 2 not divide by 4");
   v_ratio_decode_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in)
      fb_vp_q[1:0] == 2'h0 |=> fb_ratio_out.v == 3'h5)
      else $error("first divider code 0 not divide by 5");
   n_ratio_follow_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in)
      fb_n_q[5:0] != 6'h00 |=> fb_ratio_out.n == $past(fb_n_q[5:0]))
      else $error("third divider does not follow field");
   lanes_common_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
      ##1 lane_pre_emphasis_level_out[LANES-1] == $past(pe_q[3:0])
      && lane_pre_emphasis_level_out[0] == $past(pe_q[3:0]))
      else $error("lane pre-emphasis differs from field");
   pin_override_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in)
      ovr_q[7] |=> pll_enable_out == $past(ovr_q[0]))
      else $error("override does not steer pll enable");
   reserved_hold_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in)
      fb_vp_q[3:2] == 2'h3 |=> $stable(fb_ratio_out.p))
      else $error("reserved code changed second ratio");
   total_product_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in)
      ##1 total_ratio_out == 11'($past(fb_ratio_out.v)) *
      11'($past(fb_ratio_out.p)) * 11'($past(fb_ratio_out.n)))
      else $error("total ratio is not the product");
endmodule

// ==== tb/tb_sampling_pll_divider_config.sv ====
// self-checking bench for the sampling pll divider configuration block
`timescale 1ns/100ps
module tb_sampling_pll_divider_config;
   localparam int LANES = 4;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic sclk = 1'b0;
   logic csn = 1'b1;
   logic sdi = 1'b0;
   logic pin_en = 1'b0;
   logic sdo;
   logic sdo_oe;
   logic pll_en;
   logic ref_en;
   pll_cfg_pkg::fb_ratio_s ratio;
   logic [pll_cfg_pkg::TOTAL_W-1:0] total;
   logic [pll_cfg_pkg::BIAS_W-1:0] bias;
   logic [LANES-1:0][pll_cfg_pkg::PE_W-1:0] pe;
   int fails = 0;
   int cmp_count = 0;
   logic [7:0] rd;

   always #25 clock_in = ~clock_in;

   sampling_pll_divider_config #(.LANES(LANES)) dut (
      .clock_in(clock_in), .rstn_in(rstn_in),
      .spi_sclk_in(sclk), .spi_csn_in(csn), .spi_sdi_in(sdi),
      .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
      .pll_enable_pin_in(pin_en), .pll_enable_out(pll_en),
      .ref_out_enable_out(ref_en), .fb_ratio_out(ratio),
      .total_ratio_out(total), .oscillator_bias_level_out(bias),
      .lane_pre_emphasis_level_out(pe));

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_in);
   endtask

   // six cycles a level keeps sclk well clear of the pin synchroniser
   task automatic frame(input logic r, input logic [14:0] a,
                        input logic [7:0] wd, output logic [7:0] q);
      logic [23:0] f;
      f = {r, a, wd};
      q = 8'h00;
      csn = 1'b0;
      cyc(3);
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = f[i];
         cyc(6);
         if (i < 8) q[i] = sdo;
         if (i == 7) chk(16'(sdo_oe), 16'(r));
         sclk = 1'b1;
         cyc(6);
      end
      sclk = 1'b0;
      cyc(4);
      csn = 1'b1;
      cyc(8);
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      frame(1'b0, a, d, q);
   endtask

   task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
      frame(1'b1, a, 8'h00, rd);
      chk(16'(rd), 16'(exp));
   endtask

   task automatic t_reset;
      chk(16'(ratio.v), 16'h5);
      chk(16'(ratio.p), 16'h1);
      chk(16'(ratio.n), 16'h20);
      chk(16'(total), 16'd160);
      chk(16'(bias), 16'h4f);
      rdchk(15'h003c, 8'h01);
      rdchk(15'h003d, 8'h00);
      rdchk(15'h003e, 8'h20);
      rdchk(15'h003f, 8'h4f);
      rdchk(15'h0048, 8'h00);
      rdchk(15'h0058, 8'h00);
   endtask

   task automatic t_ref;
      chk(16'(ref_en), 16'h0);
      pin_en = 1'b1;
      cyc(8);
      chk(16'(pll_en), 16'h1);
      chk(16'(ref_en), 16'h1);
      wr(15'h003c, 8'h00);
      chk(16'(ref_en), 16'h0);
      wr(15'h003c, 8'h01);
      chk(16'(ref_en), 16'h1);
   endtask

   task automatic t_ovr;
      wr(15'h0058, 8'h80);
      chk(16'(pll_en), 16'h0);
      chk(16'(ref_en), 16'h0);
      pin_en = 1'b0;
      wr(15'h0058, 8'h81);
      chk(16'(pll_en), 16'h1);
      wr(15'h0058, 8'h00);
      chk(16'(pll_en), 16'h0);
   endtask

   task automatic t_div;
      int vt[3] = '{5, 4, 3};
      int pt[3] = '{1, 2, 4};
      // pll kept disabled while dividers change
      pin_en = 1'b0;
      for (int v = 0; v < 3; v++) begin
         for (int p = 0; p < 3; p++) begin
            wr(15'h003d, {4'h0, 2'(p), 2'(v)});
            chk(16'(ratio.v), 16'(vt[v]));
            chk(16'(ratio.p), 16'(pt[p]));
            chk(16'(total), 16'(vt[v] * pt[p] * 32));
         end
      end
      wr(15'h003d, 8'h0f);
      chk(16'(ratio.v), 16'h3);
      chk(16'(ratio.p), 16'h4);
      rdchk(15'h003d, 8'h0f);
      wr(15'h003d, 8'h00);
      wr(15'h003e, 8'h3f);
      chk(16'(total), 16'd315);
      wr(15'h003e, 8'h01);
      chk(16'(ratio.n), 16'h1);
      wr(15'h003e, 8'h00);
      chk(16'(ratio.n), 16'h1);
      chk(16'(total), 16'd5);
      wr(15'h003e, 8'h20);
   endtask

   task automatic t_misc;
      wr(15'h003f, 8'h4a);
      chk(16'(bias), 16'h4a);
      rdchk(15'h003f, 8'h4a);
      wr(15'h0048, 8'h0a);
      for (int i = 0; i < LANES; i++) chk(16'(pe[i]), 16'ha);
      rdchk(15'h0048, 8'h0a);
      // unmapped place: write dropped, read gives zero
      wr(15'h0040, 8'h55);
      rdchk(15'h0040, 8'h00);
   endtask

   initial begin
      cyc(12);
      rstn_in = 1'b1;
      cyc(4);
      t_reset();
      t_ref();
      t_ovr();
      t_div();
      t_misc();
      summarize();
   end

   // hang guard well above the expected run length
   initial begin
      repeat (60000) @(posedge clock_in);
      fails++;
      summarize();
   end
endmodule
